//--- design/fpac_ctrl.sv
// flash protection and access controller top
`timescale 1ns/1ps
`include "fpac_map.svh"
module fpac_ctrl
    import fpac_pkg::*;
#(
    parameter int SECTIONS = 16
) (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_cpu_req,
    input  wire logic        i_cpu_wr,
    input  wire logic        i_cpu_byte,
    input  wire logic [23:0] i_cpu_addr,
    input  wire logic [15:0] i_cpu_wdata,
    input  wire logic        i_pe,
    input  wire logic        i_mer,
    input  wire logic        i_wer_wr,
    input  wire logic [1:0]  i_wer_sel,
    input  wire logic [15:0] i_wer_wdata,
    input  wire logic        i_iba_wr,
    input  wire logic        i_iba_sel,
    input  wire logic [7:0]  i_iba_wdata,
    input  wire logic        i_ibd_rd,
    input  wire logic        i_ibd_wr,
    input  wire logic        i_ibd_sel,
    input  wire logic [15:0] i_ibd_wdata,
    input  wire logic [15:0] i_arr_rdata,
    input  wire logic [1:0]  i_arr_done,
    output logic             o_cpu_ack,
    output logic             o_cpu_err,
    output logic [15:0]      o_cpu_rdata,
    output logic             o_ib_ack,
    output logic             o_ib_err,
    output logic [15:0]      o_ib_rdata,
    output logic [15:0]      o_prog_blk0_section_wr_en,
    output logic [15:0]      o_prog_blk1_section_wr_en,
    output logic [15:0]      o_data_flash_section_wr_en,
    output logic [7:0]       o_prog_info_addr_reg,
    output logic [7:0]       o_data_info_addr_reg,
    output logic [15:0]      o_protection_shadow_reg,
    output logic             o_flash_busy_flag,
    output logic             o_prog_busy,
    output logic             o_data_busy,
    output logic             o_prog_pipe_full,
    output logic             o_data_pipe_full,
    output logic             o_write_lock,
    output logic             o_ext_read_lock,
    output logic             o_arr_valid,
    output logic [2:0]       o_arr_op,
    output logic             o_arr_flash,
    output logic             o_arr_info,
    output logic [23:0]      o_arr_addr,
    output logic [15:0]      o_arr_wdata
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        fpac_state_t state;
        logic        ack;
        logic        err;
        logic        ib_ack;
        logic        ib_err;
        logic        rd_info;
        logic        rd_byte;
        logic        rd_hi;
        logic [15:0] rdata;
        logic [15:0] ib_rdata;
        logic [15:0] wer0;
        logic [15:0] wer1;
        logic [15:0] werd;
        logic [7:0]  iba_p;
        logic [7:0]  iba_d;
        logic [15:0] prot;
        logic [1:0]  run;
        logic [1:0]  pend;
        fpac_cmd_t   pcmd0;
        fpac_cmd_t   pcmd1;
        logic        fbusy;
        logic [1:0]  busy;
        logic        wlock;
        logic        rlock;
        logic        av;
        fpac_op_t    aop;
        logic        afl;
        logic        ainf;
        logic [23:0] aadr;
        logic [15:0] adat;
    } fpac_regs_t;

    fpac_regs_t r_reg;
    fpac_regs_t r_next;

    if (SECTIONS != 16) begin : g_bad_sections
        $error("fpac_ctrl: only sixteen sections per block are supported");
    end

    // ---------------------------------------------------------------
    // protection decode from the shadow word
    // ---------------------------------------------------------------
    logic        wlock_dec;
    logic        rlock_dec;
    logic [23:0] boot_end; // first code-area byte

    // majority-zero decoders
    fpac_majority u_wr_lock (
        .i_field  (r_reg.prot[`FPAC_WRP_LSB +: 3]),
        .o_active (wlock_dec)
    );
    fpac_majority u_rd_lock (
        .i_field  (r_reg.prot[`FPAC_RDP_LSB +: 3]),
        .o_active (rlock_dec)
    );

    // inverted boot field counts 1K blocks; 111b gives zero
    always_comb begin
        logic [2:0] boot_blk; // inverted before widening
        boot_blk = ~r_reg.prot[`FPAC_BOOT_LSB +: 3];
        boot_end = 24'(boot_blk) << `FPAC_BOOT_SHIFT;
    end

    // ---------------------------------------------------------------
    // address decode and write checks
    // ---------------------------------------------------------------
    logic       m_hit;
    logic       m_fl;
    logic       m_blk1;
    logic [3:0] m_sec;
    logic       m_secen;
    logic       m_allen;
    logic       m_boot;
    logic       ib_fl;
    logic [7:0] ib_adr;
    logic       ib_ok;
    logic       ib_wok;

    // main block decode in cpu space
    always_comb begin
        m_fl   = 1'b0;
        m_blk1 = i_cpu_addr >= `FPAC_BLK1_BASE;
        m_hit  = i_cpu_addr <= `FPAC_PROG_END;
        m_sec  = i_cpu_addr[`FPAC_PSEC_LSB +: 4];
        if (i_cpu_addr >= `FPAC_DATA_BASE &&
            i_cpu_addr <= `FPAC_DATA_END) begin
            m_hit = 1'b1;
            m_fl  = 1'b1;
            m_sec = i_cpu_addr[`FPAC_DSEC_LSB +: 4];
        end
        if (m_fl) begin
            m_secen = r_reg.werd[m_sec];
            m_allen = &r_reg.werd;
        end else if (m_blk1) begin
            m_secen = r_reg.wer1[m_sec];
            m_allen = &r_reg.wer1;
        end else begin
            m_secen = r_reg.wer0[m_sec];
            m_allen = &r_reg.wer0;
        end
        // boot region: writes and erases of block 0 refused
        m_boot = !m_fl && !m_blk1 && (boot_end != 24'h000000) &&
                 (i_mer || i_cpu_addr < boot_end);
    end

    // info block decode; bit 0 forced clear for word access
    always_comb begin
        ib_fl  = i_ibd_sel;
        ib_adr = ib_fl ? r_reg.iba_d : r_reg.iba_p;
        ib_ok  = ib_fl ? !ib_adr[7] : 1'b1;
        if (ib_fl) begin
            ib_wok = !wlock_dec;
        end else begin
            // block 0 never writable, block 1 under enable and lock
            ib_wok = ib_adr[7] && r_reg.wer1[0] && !wlock_dec;
        end
    end

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        fpac_cmd_t cmd;
        logic      slot;
        logic      busy_p;
        logic      busy_d;
        logic      wr_ok;
        logic      fl;
        cmd   = '0;
        slot  = 1'b1;
        wr_ok = 1'b0;
        fl    = m_fl; // flash targeted by the write dispatch
        r_next = r_reg;
        r_next.ack    = 1'b0;
        r_next.err    = 1'b0;
        r_next.ib_ack = 1'b0;
        r_next.ib_err = 1'b0;
        r_next.av     = 1'b0;
        busy_p = r_reg.run[0] | r_reg.pend[0];
        busy_d = r_reg.run[1] | r_reg.pend[1];

        // section enable masks
        if (i_wer_wr) begin
            unique case (i_wer_sel)
                2'h0: r_next.wer0 = i_wer_wdata;
                2'h1: r_next.wer1 = i_wer_wdata;
                2'h2: r_next.werd = i_wer_wdata;
                default: r_next.wer0 = r_reg.wer0;
            endcase
        end
        // info address registers, word aligned
        if (i_iba_wr && !i_iba_sel) begin
            r_next.iba_p = {i_iba_wdata[7:1], 1'b0};
        end
        if (i_iba_wr && i_iba_sel) begin
            r_next.iba_d = {i_iba_wdata[7:1], 1'b0};
        end
        // completion of array operations
        for (int f = 0; f < 2; f++) begin
            if (i_arr_done[f]) begin
                r_next.run[f] = 1'b0;
            end
        end
        // queued request goes out once its flash is idle, program queue before data
        if (r_reg.pend[0] && !r_reg.run[0]) begin
            r_next.av = 1'b1;
            {r_next.aop, r_next.ainf, r_next.aadr, r_next.adat} = r_reg.pcmd0;
            r_next.afl = 1'b0;
            r_next.run[0] = 1'b1;
            r_next.pend[0] = 1'b0;
            slot = 1'b0;
        end else if (r_reg.pend[1] && !r_reg.run[1]) begin
            r_next.av = 1'b1;
            {r_next.aop, r_next.ainf, r_next.aadr, r_next.adat} = r_reg.pcmd1;
            r_next.afl = 1'b1;
            r_next.run[1] = 1'b1;
            r_next.pend[1] = 1'b0;
            slot = 1'b0;
        end

        unique case (r_reg.state)
            FPAC_ST_BOOT_REQ: begin
                // fetch the protection word into the shadow
                r_next.av    = 1'b1;
                r_next.aop   = FPAC_OP_READ;
                r_next.afl   = 1'b0;
                r_next.ainf  = 1'b1;
                r_next.aadr  = {16'h0000, `FPAC_PROT_ADDR};
                r_next.state = FPAC_ST_BOOT_WAIT;
            end
            FPAC_ST_BOOT_WAIT: begin
                r_next.prot  = i_arr_rdata;
                r_next.state = FPAC_ST_IDLE;
            end
            FPAC_ST_RD_WAIT: begin
                if (r_reg.rd_info) begin
                    r_next.ib_rdata = i_arr_rdata;
                    r_next.ib_ack   = 1'b1;
                end else begin
                    r_next.rdata = !r_reg.rd_byte ? i_arr_rdata :
                        (r_reg.rd_hi ? {8'h00, i_arr_rdata[15:8]} :
                                       {8'h00, i_arr_rdata[7:0]});
                    r_next.ack = 1'b1;
                end
                r_next.state = FPAC_ST_IDLE;
            end
            FPAC_ST_IDLE: begin
                if (i_cpu_req && !r_reg.ack && slot) begin
                    if (!m_hit) begin
                        r_next.ack = 1'b1;
                        r_next.err = 1'b1;
                    end else if (!i_cpu_wr) begin
                        // held off while the flash is busy
                        if (m_fl ? !(busy_p || busy_d) : !busy_p) begin
                            r_next.av      = 1'b1;
                            r_next.aop     = FPAC_OP_READ;
                            r_next.afl     = m_fl;
                            r_next.ainf    = 1'b0;
                            r_next.aadr    = {i_cpu_addr[23:1], 1'b0};
                            r_next.rd_info = 1'b0;
                            r_next.rd_byte = i_cpu_byte;
                            r_next.rd_hi   = i_cpu_addr[0];
                            r_next.state   = FPAC_ST_RD_WAIT;
                        end
                    end else begin
                        // decoded lock: the registered copy lags the shadow
                        wr_ok = !wlock_dec && !m_boot && !i_cpu_byte &&
                                !i_cpu_addr[0] && (i_pe || i_mer) &&
                                (i_mer ? m_allen : m_secen);
                        cmd.op   = i_mer ? FPAC_OP_ERMAIN : FPAC_OP_PROG;
                        cmd.info = 1'b0;
                        cmd.addr = i_cpu_addr;
                        cmd.data = i_cpu_wdata;
                    end
                end else if ((i_ibd_rd || i_ibd_wr) && !r_reg.ib_ack &&
                             slot) begin
                    if (!ib_ok) begin
                        r_next.ib_ack = 1'b1;
                        r_next.ib_err = 1'b1;
                    end else if (i_ibd_rd) begin
                        if (ib_fl ? !(busy_p || busy_d) : !busy_p) begin
                            r_next.av      = 1'b1;
                            r_next.aop     = FPAC_OP_READ;
                            r_next.afl     = ib_fl;
                            r_next.ainf    = 1'b1;
                            r_next.aadr    = {16'h0000, ib_adr};
                            r_next.rd_info = 1'b1;
                            r_next.state   = FPAC_ST_RD_WAIT;
                        end
                    end else begin
                        wr_ok = ib_wok && (i_pe || i_mer);
                        fl    = ib_fl;
                        // info erase takes its main block along
                        cmd.op   = i_mer ? FPAC_OP_ERINFO : FPAC_OP_PROG;
                        cmd.info = 1'b1;
                        cmd.addr = {16'h0000, ib_adr};
                        cmd.data = i_ibd_wdata;
                    end
                end
                // write dispatch: issue, queue, stall or refuse
                if (cmd.info || (i_cpu_req && i_cpu_wr && !r_reg.ack &&
                                 slot && m_hit)) begin
                    if (!wr_ok) begin
                        if (cmd.info) begin
                            r_next.ib_ack = 1'b1;
                            r_next.ib_err = 1'b1;
                        end else begin
                            r_next.ack = 1'b1;
                            r_next.err = 1'b1;
                        end
                    end else if (!r_reg.pend[fl]) begin
                        if (cmd.info) begin
                            r_next.ib_ack = 1'b1;
                        end else begin
                            r_next.ack = 1'b1;
                        end
                        if (!r_reg.run[fl]) begin
                            r_next.av = 1'b1;
                            {r_next.aop, r_next.ainf, r_next.aadr,
                             r_next.adat} = cmd;
                            r_next.afl = fl;
                            r_next.run[fl] = 1'b1;
                        end else if (fl) begin
                            r_next.pcmd1   = cmd;
                            r_next.pend[1] = 1'b1;
                        end else begin
                            r_next.pcmd0   = cmd;
                            r_next.pend[0] = 1'b1;
                        end
                    end
                end
            end
        endcase

        r_next.fbusy = |(r_next.run | r_next.pend);
        r_next.busy  = r_next.run | r_next.pend;
        r_next.wlock = wlock_dec;
        r_next.rlock = rlock_dec;

        if (i_sys_rst) begin
            r_next       = '0;
            r_next.state = FPAC_ST_BOOT_REQ;
            r_next.prot  = `FPAC_PROT_RST;
            r_next.wer0  = `FPAC_MASK_RST;
            r_next.wer1  = `FPAC_MASK_RST;
            r_next.werd  = `FPAC_MASK_RST;
            r_next.wlock = 1'b1;
        end
    end

    // state register
    always_ff @(posedge i_clk) begin
        r_reg <= r_next;
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign o_cpu_ack   = r_reg.ack;
    assign o_cpu_err   = r_reg.err;
    assign o_cpu_rdata = r_reg.rdata;
    assign o_ib_ack    = r_reg.ib_ack;
    assign o_ib_err    = r_reg.ib_err;
    assign o_ib_rdata  = r_reg.ib_rdata;
    assign o_prog_blk0_section_wr_en  = r_reg.wer0;
    assign o_prog_blk1_section_wr_en  = r_reg.wer1;
    assign o_data_flash_section_wr_en = r_reg.werd;
    assign o_prog_info_addr_reg    = r_reg.iba_p;
    assign o_data_info_addr_reg    = r_reg.iba_d;
    assign o_protection_shadow_reg = r_reg.prot;
    assign o_flash_busy_flag = r_reg.fbusy;
    assign o_prog_busy       = r_reg.busy[0];
    assign o_data_busy       = r_reg.busy[1];
    assign o_prog_pipe_full  = r_reg.pend[0];
    assign o_data_pipe_full  = r_reg.pend[1];
    assign o_write_lock      = r_reg.wlock;
    assign o_ext_read_lock   = r_reg.rlock;
    assign o_arr_valid = r_reg.av;
    assign o_arr_op    = r_reg.aop;
    assign o_arr_flash = r_reg.afl;
    assign o_arr_info  = r_reg.ainf;
    assign o_arr_addr  = r_reg.aadr;
    assign o_arr_wdata = r_reg.adat;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    logic is_wr_op;
    assign is_wr_op = o_arr_valid && o_arr_op != FPAC_OP_READ;

    a_mask_reset: assert property ($fell(i_sys_rst) |->
        o_prog_blk0_section_wr_en == 16'h0000 &&
        o_data_flash_section_wr_en == 16'h0000)
        else $error("section masks not cleared by reset");
    a_boot_locked: assert property (is_wr_op && !o_arr_flash &&
        !o_arr_info && o_arr_op == FPAC_OP_PROG |->
        o_arr_addr >= boot_end)
        else $error("write issued into boot region");
    a_global_lock: assert property (is_wr_op |->
        !$past(o_write_lock, 2) || !$past(o_write_lock))
        else $error("write issued under global write lock");
    a_ib0_locked: assert property (is_wr_op && o_arr_info &&
        !o_arr_flash |-> o_arr_addr[7])
        else $error("write issued into program info block 0");
    a_info_align: assert property (o_arr_valid && o_arr_info |->
        !o_arr_addr[0])
        else $error("info access not word aligned");
    a_data_rd_gate: assert property (o_arr_valid &&
        o_arr_op == FPAC_OP_READ && o_arr_flash |->
        $past(!o_prog_busy && !o_data_busy))
        else $error("data read while flash busy");
    a_busy_follow: assert property (is_wr_op |->
        o_flash_busy_flag ##1 o_flash_busy_flag || o_arr_valid)
        else $error("busy flag not set during operation");
    a_full_rise: assert property ($rose(o_prog_pipe_full) |->
        $past(r_reg.run[0]))
        else $error("pipe full raised with program flash idle");
    a_shadow_hold: assert property (r_reg.state != FPAC_ST_BOOT_WAIT
        |=> $stable(o_protection_shadow_reg))
        else $error("protection shadow changed outside reset load");
    a_ack_pulse: assert property (o_cpu_ack |=> !o_cpu_ack)
        else $error("cpu ack longer than one cycle");

    c_prog_issue: cover property (is_wr_op && o_arr_op == FPAC_OP_PROG);
    c_pipe_full: cover property (o_prog_pipe_full ##[1:40] !o_prog_pipe_full);
    c_blocked_wr: cover property (o_cpu_ack && o_cpu_err);
    c_info_read: cover property (o_ib_ack && !o_ib_err);
endmodule : fpac_ctrl

//--- inc/fpac_map.svh
// offsets, field positions and reset values of the flash controller
`ifndef FPAC_MAP_SVH
`define FPAC_MAP_SVH
// Summary of operation
// - boot region spans address zero up to a programmable end, at most 1BFFh
// - cpu writes into the boot region are always refused, reads allowed
// - code area follows boot; writes need section enable and no global lock
// - one enable bit per 8K program section and per 512-byte data section
// - reset clears all three section write-enable masks
// - each main block has sixteen sections; mask bit zero is lowest section
// - majority-zero write-lock field blocks every cpu flash write
// - majority-zero read-lock field blocks debugger and programmer reads
// - two program blocks and one data block decoded in cpu space
// - info blocks reached only through per-flash address/data registers
// - program info block zero readable, never writable by the cpu
// - protection word writable normally, takes effect after next reset
// - erasing an info block also erases its main block
// - data info block always readable, writable only without global lock
// - erase sets all bits to one; programming only clears bits
// - programming is pipelined; new request loads once full flag clears
// - program reads wait for program idle; data reads wait for both idle
// - info reads are word wide at word-aligned addresses
// - info read: write address register, then read the data register
// - busy flag set while either flash programs or erases
// - full flag rises when a write is issued while one is in progress
// - boot size is inverted boot field times 1024 bytes; 111b means none
// - protection word copied into a shadow at reset and used until next
`define FPAC_BLK1_BASE     24'h020000
`define FPAC_PROG_END      24'h03ffff
`define FPAC_DATA_BASE     24'h0e0000
`define FPAC_DATA_END      24'h0e1fff
`define FPAC_BOOT_MAX      24'h001bff
`define FPAC_BOOT_SHIFT    10
`define FPAC_PSEC_LSB      13
`define FPAC_DSEC_LSB      9
`define FPAC_IB1_BASE      8'h80
`define FPAC_PROT_ADDR     8'hfe
`define FPAC_FUNC_ADDR     8'h7e
`define FPAC_WRP_LSB       13
`define FPAC_RDP_LSB       10
`define FPAC_BOOT_LSB      1
`define FPAC_PROT_RST      16'hffff
`define FPAC_MASK_RST      16'h0000
`endif

//--- inc/fpac_pkg.sv
// types of the flash protection and access controller
package fpac_pkg;
    typedef enum logic [3:0] {
        FPAC_ST_BOOT_REQ  = 4'h1,
        FPAC_ST_BOOT_WAIT = 4'h2,
        FPAC_ST_IDLE      = 4'h4,
        FPAC_ST_RD_WAIT   = 4'h8
    } fpac_state_t;
    typedef enum logic [2:0] {
        FPAC_OP_READ  = 3'h0,
        FPAC_OP_PROG  = 3'h1,
        FPAC_OP_ERMAIN = 3'h2,
        FPAC_OP_ERINFO = 3'h3
    } fpac_op_t;
    typedef struct packed {
        fpac_op_t    op;
        logic        info;
        logic [23:0] addr;
        logic [15:0] data;
    } fpac_cmd_t;
endpackage : fpac_pkg

//--- design/fpac_majority.sv
// majority-of-zeros decoder for a three-bit protection field
`timescale 1ns/1ps
module fpac_majority (
    input  wire logic [2:0] i_field,
    output logic            o_active
);
    // active when two or more bits are clear
    always_comb begin
        o_active = (~i_field[0] & ~i_field[1]) | (~i_field[0] & ~i_field[2])
                 | (~i_field[1] & ~i_field[2]);
    end
endmodule : fpac_majority

//--- bench/fpac_flash_model.sv
// behavioural flash array answering the controller's command pulses
`timescale 1ns/1ps
module fpac_flash_model #(
    parameter logic [15:0] PROT = 16'he3fd,
    parameter int          DLY  = 6
) (
    input  wire logic        i_clk,
    input  wire logic        i_valid,
    input  wire logic [2:0]  i_op,
    input  wire logic        i_flash,
    input  wire logic        i_info,
    input  wire logic [23:0] i_addr,
    output logic [15:0]      o_rdata,
    output logic [1:0]       o_done
);
    int cnt [2] = '{0, 0};
    logic [15:0] tog = 16'h1234;
    // read word within the command cycle, a toggling word otherwise
    always_comb begin
        if (i_valid && i_op == 3'h0 && i_info && i_addr[7:0] == 8'hfe)
            o_rdata = PROT;
        else if (i_valid && i_op == 3'h0)
            o_rdata = i_addr[15:0] ^ 16'h5a5a;
        else
            o_rdata = tog;
    end
    always @(posedge i_clk) begin
        tog <= ~tog;
        // slow program or erase: done pulses DLY cycles after the command
        for (int f = 0; f < 2; f++) begin
            o_done[f] <= (cnt[f] == 1);
            if (i_valid && i_op != 3'h0 && i_flash == f)
                cnt[f] <= DLY;
            else if (cnt[f] > 0)
                cnt[f] <= cnt[f] - 1;
        end
    end
endmodule : fpac_flash_model

//--- bench/testbench.sv
// self-checking bench of the flash protection and access controller
`timescale 1ns/1ps
module testbench;
    import fpac_pkg::*;
    logic        i_clk = 0, i_sys_rst = 1, i_cpu_req = 0, i_cpu_wr = 0;
    logic        i_cpu_byte = 0, i_pe = 1, i_mer = 0, i_wer_wr = 0;
    logic        i_iba_wr = 0, i_iba_sel = 0, i_ibd_rd = 0, i_ibd_wr = 0;
    logic        i_ibd_sel = 0, o_cpu_ack, o_cpu_err, o_ib_ack, o_ib_err;
    logic        o_flash_busy_flag, o_prog_busy, o_data_busy, o_arr_info;
    logic        o_prog_pipe_full, o_data_pipe_full, o_write_lock;
    logic        o_ext_read_lock, o_arr_valid, o_arr_flash;
    logic [1:0]  i_wer_sel = 0, i_arr_done;
    logic [2:0]  o_arr_op;
    logic [7:0]  i_iba_wdata = 0, o_prog_info_addr_reg, o_data_info_addr_reg;
    logic [15:0] i_cpu_wdata = 0, i_wer_wdata = 0, i_ibd_wdata = 0;
    logic [15:0] i_arr_rdata, o_cpu_rdata, o_ib_rdata, o_arr_wdata;
    logic [15:0] o_prog_blk0_section_wr_en, o_prog_blk1_section_wr_en;
    logic [15:0] o_data_flash_section_wr_en, o_protection_shadow_reg;
    logic [23:0] i_cpu_addr = 0, o_arr_addr;
    logic [31:0] seed = 32'd74778;
    logic [23:0] a;
    int          n_mismatch = 0, checked = 0;
    fpac_ctrl fpac_ctrl_inst (.*);
    fpac_flash_model fpac_flash_model_inst (.i_clk(i_clk), .i_valid(o_arr_valid),
        .i_op(o_arr_op), .i_flash(o_arr_flash), .i_info(o_arr_info),
        .i_addr(o_arr_addr), .o_rdata(i_arr_rdata), .o_done(i_arr_done));
    initial forever #5 i_clk = ~i_clk;
    //--------------------------------------------------------------
    // helpers
    //--------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs
    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // bounded wait: 0 cpu ack, 1 info ack, 2 flash idle
    task automatic wt(input int w);
        int k;
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while (!(w == 0 ? o_cpu_ack === 1'b1 : w == 1 ? o_ib_ack === 1'b1
                     : o_flash_busy_flag === 1'b0) && k < 99);
        if (k >= 99) begin
            n_mismatch++;
            conclude();
        end
    endtask : wt
    // cpu access; reads expect the array word scrambled from the address
    task automatic cpu(input logic w, input logic [23:0] ad, input logic e);
        i_cpu_req   <= 1'b1;
        i_cpu_wr    <= w;
        i_cpu_addr  <= ad;
        i_cpu_wdata <= seed[31:16];
        wt(0);
        i_cpu_req   <= 1'b0;
        chk(16'(o_cpu_err), 16'(e));
        if (!w && !e)
            chk(o_cpu_rdata, ad[15:0] ^ 16'h5a5a);
        @(posedge i_clk);
    endtask : cpu
    task automatic wer(input logic [1:0] s, input logic [15:0] d);
        i_wer_wr    <= 1'b1;
        i_wer_sel   <= s;
        i_wer_wdata <= d;
        @(posedge i_clk);
        i_wer_wr    <= 1'b0;
        @(posedge i_clk);
    endtask : wer
    // info read: load the address register, then read the data register
    task automatic ib(input logic s, input logic [7:0] ad, input logic [15:0] x);
        i_iba_wr    <= 1'b1;
        i_iba_sel   <= s;
        i_iba_wdata <= ad;
        @(posedge i_clk);
        i_iba_wr    <= 1'b0;
        i_ibd_rd    <= 1'b1;
        i_ibd_sel   <= s;
        wt(1);
        i_ibd_rd    <= 1'b0;
        chk(o_ib_rdata, x);
    endtask : ib
    initial begin
        repeat (16) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (4) @(posedge i_clk);
        chk(o_protection_shadow_reg, 16'he3fd);
        chk(16'({o_write_lock, o_ext_read_lock}), 16'h0001);
        chk(o_prog_blk0_section_wr_en | o_data_flash_section_wr_en, 16'h0);
        cpu(1'b1, 24'h020000, 1'b1);
        $display("reset state test done");
        wer(2'd0, 16'hffff);
        wer(2'd1, 16'hffff);
        wer(2'd2, 16'hffff);
        chk(o_prog_blk1_section_wr_en, 16'hffff);
        cpu(1'b1, 24'h000100, 1'b1);
        cpu(1'b1, 24'h000400, 1'b0);
        cpu(1'b0, 24'h000100, 1'b0);
        cpu(1'b1, 24'h024000, 1'b0);
        cpu(1'b1, 24'h024002, 1'b0);
        chk(16'({o_prog_pipe_full, o_flash_busy_flag}), 16'h0003);
        wt(2);
        $display("boot and pipeline test done");
        for (int n = 0; n < 8; n++) begin
            seed = xs(seed);
            a = seed[17] ? {11'h070, seed[12:1], 1'b0} : {7'h01, seed[16:1], 1'b0};
            cpu(1'b1, a, 1'b0);
            cpu(1'b0, a, 1'b0);
        end
        $display("random access test done");
        wer(2'd1, 16'hfffe);
        cpu(1'b1, 24'h020000, 1'b1);
        cpu(1'b1, 24'h022000, 1'b0);
        cpu(1'b0, 24'h050000, 1'b1);
        i_mer <= 1'b1;
        cpu(1'b1, 24'h004000, 1'b1);
        cpu(1'b1, 24'h0e0000, 1'b0);
        i_mer <= 1'b0;
        ib(1'b0, 8'hfe, 16'he3fd);
        ib(1'b1, 8'h10, 16'h0010 ^ 16'h5a5a);
        $display("section and info test done");
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (4) @(posedge i_clk);
        chk(o_prog_blk1_section_wr_en, 16'h0);
        chk(o_protection_shadow_reg, 16'he3fd);
        wer(2'd2, 16'h0001);
        cpu(1'b1, 24'h0e0000, 1'b0);
        wer(2'd2, 16'h0000);
        cpu(1'b1, 24'h0e0000, 1'b1);
        $display("mid-run reset test done");
        conclude();
    end
endmodule : testbench
